//--- design/sdirx_clkrst.sv
// clock-enable cadence, reset fan-out, lock detect and pixel buffer of the receiver
// assumes one system clock; reset pins and the stable flag arrive asynchronously
`timescale 1ns/1ps
module sdirx_clkrst (
   // clock, enable, block reset
   input wire logic clk,
   input wire logic clk_en,
   input wire logic resetn,
   // subsystem reset pins
   input wire logic reg_resetn_pin,
   input wire logic video_resetn_pin,
   input wire logic core_reset_pin,
   // mode and lock control
   input wire logic sd_mode,
   input wire logic video_stable_pin,
   input wire logic [sdirx_pkg::LOCK_W-1:0] lock_window,
   // fanned-out resets
   output logic core_reg_resetn,
   output logic core_stream_resetn,
   output logic core_rx_reset,
   output logic bridge_reset,
   // status
   output logic sd_sample_enable,
   output logic video_locked,
   output logic overflow,
   output logic underflow,
   // incoming pixel stream
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [sdirx_pkg::PIX_W-1:0] in_data,
   // outgoing pixel stream
   output logic out_valid,
   input wire logic out_ready,
   output logic [sdirx_pkg::PIX_W-1:0] out_data
);
   logic [sdirx_pkg::SYNC_W-1:0] sync1_q; // first stage, read only by second
   logic [sdirx_pkg::SYNC_W-1:0] sync2_q; // synchronised pins
   logic [sdirx_pkg::SYNC_W-1:0] pins;
   logic core_rst; // block reset or receive reset
   logic [2:0] cad_cnt_q; // cycles since last sample enable
   logic cad_long_q; // next gap is the long one
   logic [2:0] cad_limit;
   logic [sdirx_pkg::LOCK_W-1:0] lock_cnt_q; // consecutive stable cycles
   logic [sdirx_pkg::LOCK_W-1:0] lock_cnt_inc;
   logic take; // sample qualifies this cycle
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic fifo_rd_ready;
   logic [sdirx_pkg::PIX_W-1:0] fifo_rd_data;
   logic sd_sample_enable_q;
   logic video_locked_q;
   logic overflow_q;
   logic underflow_q;
   logic out_valid_q;
   logic [sdirx_pkg::PIX_W-1:0] out_data_q;
   logic core_reg_resetn_q;
   logic core_stream_resetn_q;
   logic core_rx_reset_q;
   logic bridge_reset_q;

   assign pins = {video_stable_pin, core_reset_pin, video_resetn_pin, reg_resetn_pin};

   // two-stage synchroniser per pin
   genvar gi;
   for (gi = 0; gi < sdirx_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
         if (!resetn) begin
            sync1_q[gi] <= sdirx_pkg::SYNC_RST[gi];
            sync2_q[gi] <= sdirx_pkg::SYNC_RST[gi];
         end else if (clk_en) begin
            sync1_q[gi] <= pins[gi];
            sync2_q[gi] <= sync1_q[gi];
         end
      end
   end

   // receive reset as seen by core and bridge logic here
   assign core_rst = !resetn || sync2_q[sdirx_pkg::SYNC_CORE];

   // reset fan-out, each domain reset kept to its own targets
   always_ff @(posedge clk) begin
      if (!resetn) begin
         core_reg_resetn_q <= 1'b0;
         core_stream_resetn_q <= 1'b0;
         core_rx_reset_q <= 1'b1;
         bridge_reset_q <= 1'b1;
      end else if (clk_en) begin
         core_reg_resetn_q <= sync2_q[sdirx_pkg::SYNC_REG_N];
         core_stream_resetn_q <= sync2_q[sdirx_pkg::SYNC_VID_N];
         core_rx_reset_q <= sync2_q[sdirx_pkg::SYNC_CORE];
         bridge_reset_q <= sync2_q[sdirx_pkg::SYNC_CORE];
      end
   end

   // sd cadence: gaps alternate five and six cycles
   assign cad_limit = cad_long_q ? sdirx_pkg::CAD_LONG : sdirx_pkg::CAD_SHORT;

   always_ff @(posedge clk) begin
      if (core_rst) begin
         cad_cnt_q <= sdirx_pkg::CAD_CNT_RST;
         cad_long_q <= 1'b0;
         sd_sample_enable_q <= 1'b0;
      end else if (clk_en) begin
         if (!sd_mode) begin
            // hd and above: every cycle carries data
            cad_cnt_q <= sdirx_pkg::CAD_CNT_RST;
            cad_long_q <= 1'b0;
            sd_sample_enable_q <= 1'b1;
         end else if (cad_cnt_q == cad_limit - 3'h1) begin
            cad_cnt_q <= sdirx_pkg::CAD_CNT_RST;
            cad_long_q <= !cad_long_q;
            sd_sample_enable_q <= 1'b1;
         end else begin
            cad_cnt_q <= cad_cnt_q + 3'h1;
            sd_sample_enable_q <= 1'b0;
         end
      end
   end

   // lock detect: any unstable cycle restarts the count
   assign lock_cnt_inc = (&lock_cnt_q) ? lock_cnt_q : lock_cnt_q + 16'h0001;

   always_ff @(posedge clk) begin
      if (core_rst) begin
         lock_cnt_q <= sdirx_pkg::LOCK_CNT_RST;
         video_locked_q <= 1'b0;
      end else if (clk_en) begin
         if (!sync2_q[sdirx_pkg::SYNC_STABLE]) begin
            lock_cnt_q <= sdirx_pkg::LOCK_CNT_RST;
            video_locked_q <= 1'b0;
         end else begin
            lock_cnt_q <= lock_cnt_inc;
            video_locked_q <= (lock_cnt_inc >= lock_window);
         end
      end
   end

   // in sd mode only enabled cycles carry a sample
   assign take = in_valid && (!sd_mode || sd_sample_enable_q);

   // pixel buffer between the receive side and the output stage
   sdirx_fifo #(
      .WIDTH(sdirx_pkg::PIX_W),
      .DEPTH(sdirx_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .clk_en(clk_en),
      .rst(core_rst),
      .wr_valid(take),
      .wr_ready(fifo_wr_ready),
      .wr_data(in_data),
      .rd_valid(fifo_rd_valid),
      .rd_ready(fifo_rd_ready),
      .rd_data(fifo_rd_data)
   );

   // output stage drains when empty or when the sink takes the word
   assign fifo_rd_ready = !out_valid_q || out_ready;

   // conversion stage: only the block reset touches it, never the receive reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end else if (clk_en && fifo_rd_ready) begin
         out_valid_q <= fifo_rd_valid;
         out_data_q <= fifo_rd_data;
      end
   end

   // sticky crossing errors, cleared only by block reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         overflow_q <= 1'b0;
         underflow_q <= 1'b0;
      end else if (clk_en) begin
         if (take && !fifo_wr_ready) begin
            overflow_q <= 1'b1;
         end
         if (video_locked_q && out_ready && !out_valid_q) begin
            underflow_q <= 1'b1;
         end
      end
   end

   // outputs straight from flops
   assign core_reg_resetn = core_reg_resetn_q;
   assign core_stream_resetn = core_stream_resetn_q;
   assign core_rx_reset = core_rx_reset_q;
   assign bridge_reset = bridge_reset_q;
   assign sd_sample_enable = sd_sample_enable_q;
   assign video_locked = video_locked_q;
   assign overflow = overflow_q;
   assign underflow = underflow_q;
   assign in_ready = fifo_wr_ready;
   assign out_valid = out_valid_q;
   assign out_data = out_data_q;

   // checks; frozen cycles are excluded since the enable stalls every step
   sequence s_gap_short;
      !sd_sample_enable_q [*4] ##1 sd_sample_enable_q;
   endsequence
   sequence s_gap_long;
      !sd_sample_enable_q [*5] ##1 sd_sample_enable_q;
   endsequence

   AST_SD_CADENCE: assert property (@(posedge clk) disable iff (core_rst || !clk_en)
      (sd_mode && $past(sd_mode) && sd_sample_enable_q) |-> ##1 (s_gap_short or s_gap_long))
      else $error("sd sample enable gap not five or six cycles");

   AST_REG_RESET: assert property (@(posedge clk) disable iff (!resetn || !clk_en)
      core_reg_resetn_q == $past(sync2_q[sdirx_pkg::SYNC_REG_N]))
      else $error("register reset does not follow its pin");

   AST_VID_RESET: assert property (@(posedge clk) disable iff (!resetn || !clk_en)
      $fell(sync2_q[sdirx_pkg::SYNC_VID_N]) |=> !core_stream_resetn_q)
      else $error("stream reset not asserted after video reset");

   AST_CORE_RESET: assert property (@(posedge clk) disable iff (!resetn || !clk_en)
      (core_rx_reset_q == bridge_reset_q) and
      ($rose(sync2_q[sdirx_pkg::SYNC_CORE]) |=> core_rx_reset_q))
      else $error("core and bridge resets disagree");

   AST_CONV_NO_RESET: assert property (@(posedge clk) disable iff (!resetn || !clk_en)
      (out_valid_q && !out_ready && sync2_q[sdirx_pkg::SYNC_CORE]) |=> out_valid_q)
      else $error("output stage dropped by receive reset");

   AST_PIXEL_HOLD: assert property (@(posedge clk) disable iff (!resetn || !clk_en)
      (out_valid_q && !out_ready) |=> (out_valid_q && $stable(out_data_q)))
      else $error("pixel pair changed while stalled");

   AST_LOCK_WINDOW: assert property (@(posedge clk) disable iff (core_rst || !clk_en)
      $rose(video_locked_q) |-> (lock_cnt_q >= lock_window && $past(sync2_q[sdirx_pkg::SYNC_STABLE])))
      else $error("locked before window of stable cycles");

   AST_UNLOCK: assert property (@(posedge clk) disable iff (core_rst || !clk_en)
      !sync2_q[sdirx_pkg::SYNC_STABLE] |=> (!video_locked_q && lock_cnt_q == 16'h0000))
      else $error("lock kept through unstable cycle");

   AST_OVERFLOW: assert property (@(posedge clk) disable iff (!resetn || !clk_en)
      (take && !fifo_wr_ready) |=> overflow_q [*2])
      else $error("overflow not flagged");

   AST_UNDERFLOW: assert property (@(posedge clk) disable iff (!resetn || !clk_en)
      (video_locked_q && out_ready && !out_valid_q) |=> underflow_q)
      else $error("underflow not flagged");
endmodule : sdirx_clkrst

//--- design/sdirx_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes depth is a power of two and a synchronous active-high reset
`timescale 1ns/1ps
module sdirx_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 8
) (
   // clock, enable, reset
   input wire logic clk,
   input wire logic clk_en,
   input wire logic rst,
   // write side
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   // read side
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH]; // storage array
   logic [AW-1:0] wr_ptr_q; // next slot to write
   logic [AW-1:0] rd_ptr_q; // next slot to read
   logic [AW:0] count_q; // words held
   logic [AW:0] count_d;
   logic not_full_q; // registered ready
   logic not_empty_q; // registered valid
   logic push;
   logic pop;

   assign push = wr_valid && not_full_q;
   assign pop = rd_ready && not_empty_q;
   assign wr_ready = not_full_q;
   assign rd_valid = not_empty_q;
   assign rd_data = mem_q[rd_ptr_q];

   // occupancy arithmetic
   always_comb begin
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
   end

   // pointers and flags, flags derived from next count so they stay honest
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         not_full_q <= 1'b1;
         not_empty_q <= 1'b0;
      end else if (clk_en) begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         count_q <= count_d;
         not_full_q <= (count_d != FULL_CNT);
         not_empty_q <= (count_d != '0);
      end
   end

   // storage, no reset needed on data
   always_ff @(posedge clk) begin
      if (clk_en && push) begin
         mem_q[wr_ptr_q] <= wr_data;
      end
   end
endmodule : sdirx_fifo

//--- dv/sdirx_sink.sv
// downstream pixel-pair sink standing beside the receiver clock/reset block
// assumes the same clock as the block and the block's active-low reset
`timescale 1ns/1ps
module sdirx_sink (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // pixel-pair stream from the block
   input wire logic valid,
   input wire logic [sdirx_pkg::PIX_W-1:0] data,
   output logic ready,
   // bench control
   input wire logic stall
);
   // words taken, in arrival order; read by the bench
   logic [sdirx_pkg::PIX_W-1:0] got [$];
   // ready from a flop, so a stall shows one edge late like real user logic
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ready <= 1'b0;
      end else begin
         ready <= !stall;
      end
   end
   // same clock as the block: never slower than the feeding side
   // plain always, since the bench empties the queue between scenarios
   always @(posedge clk) begin
      if (resetn && valid && ready) begin
         got.push_back(data);
      end
   end
endmodule : sdirx_sink

//--- dv/tb.sv
// self-checking bench for the receiver clock/reset block
// assumes the sink model and package are compiled first; clk_en held high
`timescale 1ns/1ps
module tb;
   `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
      $display("unexpected %s: expected %h seen %h", nm, e, g); end end
   logic clk, resetn, reg_n, vid_n, core_p, sd_mode, stable, stall;
   logic [15:0] lock_window;
   logic in_valid, in_ready, out_valid, out_ready;
   logic [39:0] in_data, out_data;
   logic reg_o, vid_o, rx_o, br_o, sd_en, locked, ovf, unf;
   int fail_count, n_compared, cyc, t;
   int pos [$];
   // rows: pins {reg_n, vid_n, core} beside expected {reg, stream, rx}
   logic [5:0] rows [5] = '{6'h36, 6'h12, 6'h24, 6'h3f, 6'h36};
   logic [2:0] prev;
   // design, clock enable tied high
   sdirx_clkrst u_dut (.clk(clk), .clk_en(1'b1), .resetn(resetn),
      .reg_resetn_pin(reg_n), .video_resetn_pin(vid_n), .core_reset_pin(core_p),
      .sd_mode(sd_mode), .video_stable_pin(stable), .lock_window(lock_window),
      .core_reg_resetn(reg_o), .core_stream_resetn(vid_o), .core_rx_reset(rx_o),
      .bridge_reset(br_o), .sd_sample_enable(sd_en), .video_locked(locked),
      .overflow(ovf), .underflow(unf), .in_valid(in_valid), .in_ready(in_ready),
      .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data));
   sdirx_sink u_sink (.clk(clk), .resetn(resetn), .valid(out_valid), .data(out_data),
      .ready(out_ready), .stall(stall));
   // 10 MHz clock, standing in for register, receive and video clocks alike
   // rates and ratios are the integrator's
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // hang guard, well above the under two hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         stop_test();
      end
   end
   task stop_test;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   // offer words until n taken or refused; over keeps offering one refused edge
   task send(input int n, input logic [39:0] base, input bit over, output int taken);
      taken = 0;
      in_valid = 1'b1;
      while (in_ready === 1'b1 && taken < n) begin
         in_data = base + 40'(taken);
         tick(1);
         taken++;
      end
      if (over) tick(1);
      in_valid = 1'b0;
   endtask : send
   // compare the sink's words against the sent sequence, then forget them
   task drained(input int n, input logic [39:0] base);
      `CHK("word count", n, u_sink.got.size())
      for (int j = 0; j < n && j < u_sink.got.size(); j++) begin
         `CHK("word", base + 40'(j), u_sink.got[j])
      end
      u_sink.got.delete();
   endtask : drained
   // main sequence, inputs driven at the falling edge
   initial begin
      resetn = 1'b0; reg_n = 1'b0; vid_n = 1'b0; core_p = 1'b1; sd_mode = 1'b0;
      stable = 1'b0; stall = 1'b0; lock_window = 16'h0000; in_valid = 1'b0;
      in_data = 40'h00_0000_0000; prev = 3'h1;
      tick(2);
      `CHK("reset fanout", 4'h3, {reg_o, vid_o, rx_o, br_o})
      `CHK("reset ready", 1'b1, in_ready)
      resetn = 1'b1;
      // reset pin table: two edges still old, third edge new
      for (int i = 0; i < 5; i++) begin
         {reg_n, vid_n, core_p} = rows[i][5:3];
         tick(2);
         `CHK("fanout early", prev, {reg_o, vid_o, rx_o})
         tick(1);
         `CHK("fanout", rows[i][2:0], {reg_o, vid_o, rx_o})
         `CHK("bridge", rows[i][0], br_o)
         prev = rows[i][2:0];
      end
      `CHK("enable held", 1'b1, sd_en)
      // plain back-to-back stream, sink ready
      send(4, 40'h5a_5a5a_0000, 1'b0, t);
      tick(8);
      drained(4, 40'h5a_5a5a_0000);
      `CHK("no underflow unlocked", 1'b0, unf)
      // fill while the sink stalls, push once more into a full buffer
      stall = 1'b1;
      tick(2);
      send(20, 40'h3c_0000_0100, 1'b1, t);
      tick(2);
      `CHK("depth", sdirx_pkg::FIFO_DEPTH + 1, t)
      `CHK("overflow", 1'b1, ovf)
      stall = 1'b0;
      tick(24);
      drained(t, 40'h3c_0000_0100);
      `CHK("ready after drain", 1'b1, in_ready)
      // receive reset while the sink stalls: buffer cleared, output word kept
      stall = 1'b1;
      send(3, 40'h1e_0000_0200, 1'b0, t);
      core_p = 1'b1;
      tick(3);
      `CHK("held through rx reset", 1'b1, out_valid)
      `CHK("rx reset", 2'h3, {rx_o, br_o})
      core_p = 1'b0;
      tick(3);
      stall = 1'b0;
      tick(6);
      drained(1, 40'h1e_0000_0200);
      `CHK("flag kept", 1'b1, ovf)
      // lock after three stable cycles, then sink pulls from empty output
      lock_window = 16'h0003;
      stable = 1'b1;
      tick(4);
      `CHK("lock early", 1'b0, locked)
      tick(1);
      `CHK("lock", 1'b1, locked)
      tick(2);
      `CHK("underflow", 1'b1, unf)
      stable = 1'b0;
      tick(3);
      `CHK("unlock", 1'b0, locked)
      // sd cadence: pulse spacing alternates 5 and 6
      sd_mode = 1'b1;
      for (int j = 0; j < 60; j++) begin
         tick(1);
         if (sd_en === 1'b1) pos.push_back(j);
      end
      `CHK("pulses", 1'b1, pos.size() >= 7)
      `CHK("first pulse", sdirx_pkg::CAD_SHORT - 3'h1, pos[0])
      for (int j = 2; j < 6 && j + 1 < pos.size(); j++) begin
         `CHK("cadence pair", 11, pos[j+1] - pos[j-1])
         `CHK("gap", 1'b1, (pos[j+1] - pos[j]) inside {5, 6})
      end
      // source holds one word across eleven edges: only two enabled edges take it
      in_valid = 1'b1;
      in_data = 40'h77_0000_0001;
      tick(11);
      in_valid = 1'b0;
      tick(4);
      `CHK("sd words", 2, u_sink.got.size())
      `CHK("sd word", 40'h77_0000_0001, u_sink.got[0])
      // second reset in mid-run clears the sticky flags and the fan-out
      resetn = 1'b0;
      tick(2);
      `CHK("flags cleared", 2'h0, {ovf, unf})
      `CHK("fanout in reset", 4'h3, {reg_o, vid_o, rx_o, br_o})
      `CHK("enable in reset", 1'b0, sd_en)
      stop_test();
   end
endmodule : tb

//--- shared/sdirx_pkg.sv
// constants shared by the receiver clock and reset scheme block
// assumes a single 10 MHz system clock and a synchronous active-low reset
package sdirx_pkg;
   // system clock rate, used to turn times into cycles
   localparam int CLK_HZ = 10_000_000;
   // video format: two pixels per clock, ten bits per component, 4:2:2
   localparam int PIXELS_PER_CLOCK = 2;
   localparam int BITS_PER_COMPONENT = 10;
   localparam int COMPONENTS_PER_PIXEL = 2;
   localparam int PIX_W = PIXELS_PER_CLOCK * COMPONENTS_PER_PIXEL * BITS_PER_COMPONENT;
   // crossing buffer depth in words
   localparam int FIFO_DEPTH = 8;
   // sd sample cadence: short and long gap between enables
   localparam logic [2:0] CAD_SHORT = 3'h5;
   localparam logic [2:0] CAD_LONG = 3'h6;
   // lock window field width and lock counter reset value
   localparam int LOCK_W = 16;
   localparam logic [15:0] LOCK_CNT_RST = 16'h0000;
   // synchroniser: pin bits and their asserted reset values
   localparam int SYNC_W = 4;
   localparam int SYNC_REG_N = 0;
   localparam int SYNC_VID_N = 1;
   localparam int SYNC_CORE = 2;
   localparam int SYNC_STABLE = 3;
   localparam logic [3:0] SYNC_RST = 4'h4;
   // cadence counter reset
   localparam logic [2:0] CAD_CNT_RST = 3'h0;
endpackage : sdirx_pkg
